// ===== src/ddq_pkg.sv
// shared constants and types for the double-data-rate four-wire read block
package ddq_pkg;

    // ==========================================================
    // command opcodes
    // ==========================================================
    localparam logic [7:0] DDQ_OP_READ_ADDR_CFG = 8'hED;  // 3 or 4 address bytes by config
    localparam logic [7:0] DDQ_OP_READ_ADDR_4B  = 8'hEE;  // always 4 address bytes

    // ==========================================================
    // phase lengths and limits
    // ==========================================================
    localparam logic [2:0] DDQ_OPC_LAST_BIT   = 3'h7;     // opcode bit index of the 8th bit
    localparam logic [2:0] DDQ_ADDR3_LAST_NIB = 3'h5;     // six nibbles for 3 address bytes
    localparam logic [2:0] DDQ_ADDR4_LAST_NIB = 3'h7;     // eight nibbles for 4 address bytes
    localparam logic [6:0] DDQ_PRE_EDGES      = 7'h08;    // four cycles, both edges
    localparam logic [3:0] DDQ_EXIT_RISES     = 4'h8;     // short select that drops continuous
    localparam logic [3:0] DDQ_RISE_SAT       = 4'hF;     // rise counter saturation
    localparam logic [7:0] DDQ_TRAIN_RESET    = 8'h34;    // default training byte

    // highest array byte address, a plain default (a power of two less one)
    localparam logic [31:0] DDQ_ARRAY_LAST    = 32'h00FF_FFFF;

    // ==========================================================
    // latency tables, dummy cycles per latency code, entry 15 first
    // ==========================================================
    localparam logic [15:0][5:0] DDQ_HP_LAT  = '{6'h10, 6'h0F, 6'h0E, 6'h0D,
                                                 6'h0C, 6'h0B, 6'h0A, 6'h09,
                                                 6'h08, 6'h07, 6'h06, 6'h05,
                                                 6'h04, 6'h03, 6'h02, 6'h01};
    localparam logic [15:0][5:0] DDQ_ENH_LAT = '{6'h11, 6'h10, 6'h0F, 6'h0E,
                                                 6'h0D, 6'h0C, 6'h0B, 6'h0A,
                                                 6'h09, 6'h08, 6'h07, 6'h06,
                                                 6'h05, 6'h04, 6'h03, 6'h02};

    // ==========================================================
    // input synchroniser lanes
    // ==========================================================
    localparam int DDQ_SYNC_W   = 6;                      // cs, sck, four io lines
    localparam int DDQ_LANE_CS  = 0;
    localparam int DDQ_LANE_SCK = 1;
    localparam int DDQ_LANE_IO  = 2;                      // io0 lane, io3 at +3

    // ==========================================================
    // sequencer states
    // ==========================================================
    typedef enum logic [2:0] {
        DDQ_ST_IDLE,      // chip select high
        DDQ_ST_OPCODE,    // single-rate opcode on io0
        DDQ_ST_ADDR,      // double-rate address nibbles
        DDQ_ST_MODE,      // two mode nibbles
        DDQ_ST_DUMMY,     // latency, optional training tail
        DDQ_ST_DATA,      // double-rate read data
        DDQ_ST_IGNORE     // command not taken, wait for deselect
    } ddq_state_e;

endpackage

// ===== src/ddq_read_ctrl.sv
// double-data-rate four-wire read sequencer, device side
`timescale 1ns/10ps

module ddq_read_ctrl
    import ddq_pkg::*;
#(
    parameter bit USE_ENHANCED_TABLE = 1'b0   // latency table of this variant
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    input  wire logic        pause_n,
    input  wire logic        quad_enable,
    input  wire logic        extended_addressing_enable,
    input  wire logic [3:0]  latency_code_field,
    input  wire logic        training_enable,
    input  wire logic [7:0]  capture_training_pattern,
    output logic      [31:0] mem_addr,
    input  wire logic [7:0]  mem_rd_data,
    output logic             cont_mode,
    output logic             data_phase
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        ddq_state_e  st;        // sequencer phase
        logic        cont;      // continuous mode armed for next select
        logic        skip_op;   // this select began without opcode
        logic        four_byte; // address length of current command
        logic        armed;     // address capture has seen its first rise
        logic        nib_hi;    // next data edge sends the high nibble
        logic [2:0]  bit_cnt;   // opcode bit or address nibble index
        logic [3:0]  rises;     // rising edges in this select, saturating
        logic [31:0] shreg;     // opcode and address shifter
        logic [3:0]  mode_hi;   // first mode nibble
        logic [6:0]  dcnt;      // dummy edges left
        logic [31:0] addr;      // byte address counter
        logic [3:0]  byte_lo;   // low nibble held for the second edge
        logic [3:0]  io_out;    // pin drive value
        logic [3:0]  io_oe;     // pin drive enables
    } ddq_ctrl_s;

    ddq_ctrl_s r, n;

    // ==========================================================
    // pin synchronisation
    // ==========================================================
    logic [DDQ_SYNC_W-1:0] pin_q;     // agreed pin levels
    logic [DDQ_SYNC_W-1:0] pin_rise;  // one-cycle rise per lane
    logic [DDQ_SYNC_W-1:0] pin_fall;  // one-cycle fall per lane

    // io shares the sck pipeline so each edge sees the io level of its instant
    ddq_sync #(
        .W(DDQ_SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n (arst_n),
        .d      ({io_in, sck, cs_n}),
        .q      (pin_q),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    logic       cs_n_q;      // agreed select level
    logic       cs_rise;     // deselect pulse
    logic       cs_fall;     // select pulse
    logic       sck_rise;    // serial clock rising pulse
    logic       sck_edge;    // either serial clock edge
    logic [3:0] io_q;        // agreed io levels

    assign cs_n_q   = pin_q[DDQ_LANE_CS];
    assign cs_rise  = pin_rise[DDQ_LANE_CS];
    assign cs_fall  = pin_fall[DDQ_LANE_CS];
    assign sck_rise = pin_rise[DDQ_LANE_SCK];
    assign sck_edge = pin_rise[DDQ_LANE_SCK] | pin_fall[DDQ_LANE_SCK];
    assign io_q     = pin_q[DDQ_LANE_IO +: 4];

    // ==========================================================
    // next state
    // ==========================================================
    logic [5:0]  lat_cycles;   // dummy cycles for the current code
    logic [31:0] sh_next;      // shifter after one address nibble
    logic [7:0]  opc_next;     // opcode after its last bit
    logic [2:0]  pre_idx;      // training bit for this edge

    // the pause pin is deliberately unread: this command cannot be held
    // pause has no effect

    // one sequencer step per detected serial clock edge
    always_comb begin
        n        = r;
        lat_cycles = USE_ENHANCED_TABLE ? DDQ_ENH_LAT[latency_code_field]
                                        : DDQ_HP_LAT[latency_code_field];
        sh_next  = {r.shreg[27:0], io_q};
        opc_next = {r.shreg[6:0], io_q[0]};
        pre_idx  = 3'(r.dcnt - 7'h01);

        if (cs_fall) begin
            // new select: continuous mode starts straight at the address
            // opcode only when not continuous
            n.st      = r.cont ? DDQ_ST_ADDR : DDQ_ST_OPCODE;
            n.skip_op = r.cont;
            n.bit_cnt = '0;
            n.rises   = '0;
            n.armed   = 1'b0;
            n.nib_hi  = 1'b1;
            n.io_oe   = '0;
        end else if (cs_rise) begin
            // short select without a full sequence drops continuous mode
            if (r.skip_op && (r.st == DDQ_ST_ADDR || r.st == DDQ_ST_MODE) &&
                r.rises <= DDQ_EXIT_RISES) begin
                n.cont = 1'b0;
            end
            n.st    = DDQ_ST_IDLE;
            n.io_oe = '0;
        end else if (!cs_n_q && sck_edge) begin
            // rising edges counted for the short-select check
            if (sck_rise && r.rises != DDQ_RISE_SAT) begin
                n.rises = r.rises + 4'h1;
            end
            unique case (r.st)
                // nothing to do until selected, or after a refused command
                DDQ_ST_IDLE, DDQ_ST_IGNORE: begin
                    n.st = r.st;
                end
                // opcode shifted msb first on io0
                DDQ_ST_OPCODE: begin
                    if (sck_rise) begin
                        n.shreg   = {r.shreg[30:0], io_q[0]};
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == DDQ_OPC_LAST_BIT) begin
                            n.bit_cnt = '0;
                            n.armed   = 1'b0;
                            if (quad_enable && opc_next == DDQ_OP_READ_ADDR_4B) begin
                                n.four_byte = 1'b1;
                                n.st        = DDQ_ST_ADDR;
                            end else if (quad_enable && opc_next == DDQ_OP_READ_ADDR_CFG) begin
                                n.four_byte = extended_addressing_enable;
                                n.st        = DDQ_ST_ADDR;
                            end else begin
                                n.st = DDQ_ST_IGNORE;
                            end
                        end
                    end
                end
                // address nibble on every edge, from the first rise
                DDQ_ST_ADDR: begin
                    if (sck_rise || r.armed) begin
                        n.armed   = 1'b1;
                        n.shreg   = sh_next;
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == (r.four_byte ? DDQ_ADDR4_LAST_NIB
                                                      : DDQ_ADDR3_LAST_NIB)) begin
                            // out-of-range starts fold into the array
                            n.addr    = (r.four_byte ? sh_next : {8'h00, sh_next[23:0]})
                                        & DDQ_ARRAY_LAST;
                            n.bit_cnt = '0;
                            n.st      = DDQ_ST_MODE;
                        end
                    end
                end
                DDQ_ST_MODE: begin
                    if (r.bit_cnt == 3'h0) begin
                        n.mode_hi = io_q;
                        n.bit_cnt = 3'h1;
                    end else begin
                        n.cont    = (r.mode_hi == ~io_q);
                        // dummy length from the latency code
                        n.dcnt    = {lat_cycles, 1'b0};
                        n.bit_cnt = '0;
                        n.st      = DDQ_ST_DUMMY;
                    end
                end
                // latency, with the training byte in its last four cycles
                DDQ_ST_DUMMY: begin
                    n.dcnt = r.dcnt - 7'h01;
                    if (training_enable && r.dcnt <= DDQ_PRE_EDGES) begin
                        n.io_out = {4{capture_training_pattern[pre_idx]}};
                        n.io_oe  = '1;
                    end
                    if (r.dcnt == 7'h01) begin
                        n.st     = DDQ_ST_DATA;
                        n.nib_hi = 1'b1;
                    end
                end
                // a nibble per edge, high nibble first
                DDQ_ST_DATA: begin
                    n.io_oe = '1;
                    if (r.nib_hi) begin
                        n.io_out  = mem_rd_data[7:4];
                        n.byte_lo = mem_rd_data[3:0];
                        n.nib_hi  = 1'b0;
                    end else begin
                        n.io_out = r.byte_lo;
                        n.nib_hi = 1'b1;
                        // next byte, wrapping past array end
                        n.addr   = (r.addr >= DDQ_ARRAY_LAST) ? 32'h0000_0000
                                                              : r.addr + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    // ==========================================================
    // all-zero reset is idle, out of continuous mode, bus released
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // array address follows the counter; data must settle before the next edge
    assign io_out     = r.io_out;
    assign io_oe      = r.io_oe;
    assign mem_addr   = r.addr;
    assign cont_mode  = r.cont;
    assign data_phase = (r.st == DDQ_ST_DATA);

endmodule

// ===== src/ddq_sync.sv
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps

module ddq_sync
    import ddq_pkg::*;
#(
    parameter int W = DDQ_SYNC_W
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [W-1:0] s1;   // first stage, seen only by s2
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;    // accepted level
        logic [W-1:0] qd;   // accepted level one cycle back
    } ddq_sync_s;

    ddq_sync_s r, n;

    // the select lane resets to its idle high level, so leaving reset
    // never shows a false deselect edge to the sequencer
    localparam logic [W-1:0] IDLE_LVL = W'(1) << DDQ_LANE_CS;

    // ==========================================================
    // next state
    // ==========================================================
    // a lane moves only when stages two and three agree, so a lone glitch
    // sample never reaches the sequencer
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
        n.qd = r.q;
    end

    // register the whole state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{IDLE_LVL, IDLE_LVL, IDLE_LVL, IDLE_LVL, IDLE_LVL};
        end else begin
            r <= n;
        end
    end

    // pulses line up with the new level so lanes stay aligned
    assign q    = r.q;
    assign rise = r.q & ~r.qd;
    assign fall = ~r.q & r.qd;

endmodule

// ===== testbench/ddq_host_model.sv
// host controller model: select, serial clock, io drive and read capture
`timescale 1ns/10ps

module ddq_host_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] dev_out,
    input  wire logic [3:0] dev_oe,
    output logic            cs_n,
    output logic            sck,
    output logic [3:0]      io
);
    logic       host_oe;   // host drives io
    logic [3:0] host_val;  // host io value
    logic       flt;       // flips each cycle, stands in for a floating line
    logic [3:0] cap[$];    // one captured nibble per sck edge

    initial begin
        cs_n     = 1'b1;
        sck      = 1'b0;
        host_oe  = 1'b0;
        host_val = 4'h0;
        flt      = 1'b0;
    end

    always @(posedge ref_clk) flt <= ~flt;

    // released lines never hold a stale value
    assign io = (dev_oe & dev_out) | (~dev_oe & (host_oe ? host_val : {4{flt}}));

    task automatic start();
        cap.delete();
        cs_n <= 1'b0;
    endtask

    // 400 ns sck, fixed capture skew of seven cycles
    // one edge: set io, capture what the device launched two edges back, toggle
    task automatic edge_out(input logic [3:0] v, input logic drv);
        repeat (2) @(posedge ref_clk);
        host_oe  <= drv;
        host_val <= v;
        @(posedge ref_clk);
        #1 cap.push_back(io);
        @(posedge ref_clk);
        sck <= ~sck;
    endtask

    // select rises two cycles after the last sck edge; sck stands low between frames
    task automatic stop();
        repeat (2) @(posedge ref_clk);
        cs_n    <= 1'b1;
        host_oe <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// ===== testbench/ddq_read_ctrl_assertions.sv
// assertion checker for the double-data-rate four-wire read sequencer
`timescale 1ns/10ps

module ddq_read_ctrl_assertions
    import ddq_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        cs_n,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe,
    input wire logic        quad_enable,
    input wire logic        training_enable,
    input wire logic [31:0] mem_addr,
    input wire logic        cont_mode,
    input wire logic        data_phase
);
    // ==========================================================
    // helper: cycles that select has stood high
    // ==========================================================
    // saturating count, long enough to outlast the pin synchroniser
    logic [3:0] cs_hi_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            cs_hi_r <= 4'h0;
        else if (!cs_n)
            cs_hi_r <= 4'h0;
        else if (cs_hi_r != 4'hF)
            cs_hi_r <= cs_hi_r + 4'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // properties
    // ==========================================================
    property p_oe_all_lines;
        io_oe == 4'h0 || io_oe == 4'hF;
    endproperty
    a_oe_all_lines: assert property (p_oe_all_lines) else $error("io enables differ");

    property p_idle_quiet;
        cs_hi_r >= 4'h8 |-> io_oe == 4'h0 && !data_phase;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("io driven while idle");

    // without training the drive starts at the first data edge, a half sck later
    property p_data_driven;
        $rose(data_phase) |-> ##[0:8] io_oe == 4'hF;
    endproperty
    a_data_driven: assert property (p_data_driven) else $error("data not driven");

    // once driving in the data phase the lines stay driven until deselect
    property p_data_holds;
        data_phase && io_oe[0] |=> io_oe[0] || !data_phase;
    endproperty
    a_data_holds: assert property (p_data_holds) else $error("data drive dropped");

    property p_train_lines;
        io_oe == 4'hF && !data_phase && !cs_n |-> io_out == 4'h0 || io_out == 4'hF;
    endproperty
    a_train_lines: assert property (p_train_lines) else $error("training lines differ");

    property p_addr_step;
        data_phase && $past(data_phase) && $changed(mem_addr)
            |-> mem_addr == (($past(mem_addr) + 32'h1) & DDQ_ARRAY_LAST);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");

    property p_oe_needs_select;
        $rose(io_oe[0]) |-> !cs_n && $past(cs_n, 4) == 1'b0;
    endproperty
    a_oe_needs_select: assert property (p_oe_needs_select) else $error("drive without select");

    property p_oe_needs_quad;
        $rose(io_oe[0]) |-> quad_enable;
    endproperty
    a_oe_needs_quad: assert property (p_oe_needs_quad) else $error("read without quad");

    property p_cont_entry;
        $rose(cont_mode) |-> quad_enable && io_oe == 4'h0;
    endproperty
    a_cont_entry: assert property (p_cont_entry) else $error("bad continuous entry");

    property p_train_before_data;
        $rose(data_phase) && training_enable |-> $past(io_oe) == 4'hF;
    endproperty
    a_train_before_data: assert property (p_train_before_data) else $error("no preamble");

    // main scenarios reached
    c_cont: cover property ($rose(cont_mode));
    c_train: cover property ($rose(data_phase) && training_enable);
    c_wrap: cover property (data_phase && mem_addr == 32'h0 && $past(mem_addr) == DDQ_ARRAY_LAST);
endmodule

bind ddq_read_ctrl ddq_read_ctrl_assertions u_ddq_read_ctrl_assertions (
    .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe),
    .quad_enable(quad_enable), .training_enable(training_enable), .mem_addr(mem_addr),
    .cont_mode(cont_mode), .data_phase(data_phase));

// ===== testbench/ddr_quad_io_read_tb_top.sv
// self-checking bench for the double-data-rate four-wire read sequencer
`timescale 1ns/10ps

module ddr_quad_io_read_tb_top;
    import ddq_pkg::*;

    // ==========================================================
    // signals
    // ==========================================================
    logic        ref_clk;
    logic        arst_n;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic        pause_n;
    logic        quad_enable;
    logic        extended_addressing_enable;
    logic [3:0]  latency_code_field;
    logic        training_enable;
    logic [7:0]  capture_training_pattern;
    logic [31:0] mem_addr;
    logic [7:0]  mem_rd_data;
    logic        cont_mode;
    logic        data_phase;
    logic        oe_seen;      // device drove io since last clear
    int          fails;
    int          tests_run;

    ddq_read_ctrl u_ddq_read_ctrl (
        .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .io_in(io),
        .io_out(io_out), .io_oe(io_oe), .pause_n(pause_n), .quad_enable(quad_enable),
        .extended_addressing_enable(extended_addressing_enable),
        .latency_code_field(latency_code_field), .training_enable(training_enable),
        .capture_training_pattern(capture_training_pattern), .mem_addr(mem_addr),
        .mem_rd_data(mem_rd_data), .cont_mode(cont_mode), .data_phase(data_phase));

    ddq_host_model u_ddq_host_model (
        .ref_clk(ref_clk), .dev_out(io_out), .dev_oe(io_oe), .cs_n(cs_n), .sck(sck), .io(io));

    // array content: low address byte scrambled, so a wrong address shows
    assign mem_rd_data = mem_addr[7:0] ^ 8'h3C;

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) if (io_oe !== 4'h0) oe_seen <= 1'b1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic cfg(input logic q, input logic ext, input logic [3:0] code, input logic tr);
        @(posedge ref_clk);
        quad_enable                <= q;
        extended_addressing_enable <= ext;
        latency_code_field         <= code;
        training_enable            <= tr;
        repeat (2) @(posedge ref_clk);
    endtask

    // one select cycle; with chk set the preamble, data and address are judged
    task automatic frame(input logic [7:0] op, input logic use_op, input int anib,
                         input logic [31:0] addr, input logic [7:0] mode, input int nbytes,
                         input logic chk);
        int          i;
        int          dedges;
        int          base;
        logic [31:0] a;
        logic [3:0]  c[$];
        dedges = 2 * int'(DDQ_HP_LAT[latency_code_field]);
        base   = (use_op ? 16 : 0) + anib + 2;
        u_ddq_host_model.start();
        // opcode msb first on io0, sampled on rising edges
        if (use_op) for (i = 7; i >= 0; i--) begin
            u_ddq_host_model.edge_out({3'h0, op[i]}, 1'b1);
            u_ddq_host_model.edge_out({3'h0, op[i]}, 1'b1);
        end
        // address then mode, one nibble per edge
        for (i = anib - 1; i >= 0; i--) u_ddq_host_model.edge_out(addr[4*i +: 4], 1'b1);
        u_ddq_host_model.edge_out(mode[7:4], 1'b1);
        u_ddq_host_model.edge_out(mode[3:0], 1'b1);
        repeat (dedges + 2 * nbytes + 2) u_ddq_host_model.edge_out(4'h0, 1'b0);
        u_ddq_host_model.stop();
        c = u_ddq_host_model.cap;
        if (chk) begin
            for (i = 1; i <= 8 && i <= dedges && training_enable; i++)
                check(c[base + dedges - i + 2], {4{capture_training_pattern[i-1]}}, "train");
            for (i = 0; i < nbytes; i++) begin
                a = ((addr & DDQ_ARRAY_LAST) + i) & DDQ_ARRAY_LAST;
                check(c[base + dedges + 2 * i + 2], a[7:4] ^ 4'h3, "data hi");
                check(c[base + dedges + 2 * i + 3], a[3:0] ^ 4'hC, "data lo");
            end
            check(mem_addr, ((addr & DDQ_ARRAY_LAST) + nbytes + 1) & DDQ_ARRAY_LAST, "addr");
        end
    endtask

    task automatic sc_train_wrap();
        cfg(1'b1, 1'b0, 4'h3, 1'b1);
        // pause held low through a whole read
        pause_n <= 1'b0;
        frame(DDQ_OP_READ_ADDR_CFG, 1'b1, 6, 32'h00FF_FFFE, 8'h00, 3, 1'b1);
        check(cont_mode, 1'b0, "cont");
        pause_n <= 1'b1;
        $display("test train_wrap done");
    endtask

    task automatic sc_cont();
        cfg(1'b1, 1'b0, 4'h0, 1'b0);
        frame(DDQ_OP_READ_ADDR_4B, 1'b1, 8, 32'h0000_1234, 8'hA5, 2, 1'b1);
        check(cont_mode, 1'b1, "cont on");
        frame(8'h00, 1'b0, 8, 32'h0000_00F0, 8'h12, 2, 1'b1);
        $display("test cont done");
    endtask

    task automatic sc_ext_exit();
        cfg(1'b1, 1'b1, 4'h1, 1'b1);
        frame(DDQ_OP_READ_ADDR_CFG, 1'b1, 8, 32'h0000_0777, 8'h5A, 2, 1'b1);
        check(cont_mode, 1'b1, "cont again");
        u_ddq_host_model.start();
        repeat (6) u_ddq_host_model.edge_out(4'hF, 1'b1);
        u_ddq_host_model.stop();
        check(cont_mode, 1'b0, "short select");
        $display("test ext_exit done");
    endtask

    task automatic sc_refuse();
        oe_seen <= 1'b0;
        cfg(1'b0, 1'b0, 4'h0, 1'b1);
        frame(DDQ_OP_READ_ADDR_CFG, 1'b1, 6, 32'h0000_0010, 8'h00, 1, 1'b0);
        check(oe_seen, 1'b0, "no quad");
        cfg(1'b1, 1'b0, 4'h0, 1'b1);
        frame(8'h0B, 1'b1, 6, 32'h0000_0010, 8'hA5, 1, 1'b0);
        check(oe_seen, 1'b0, "bad opcode");
        check(cont_mode, 1'b0, "no cont");
        $display("test refuse done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        arst_n                     = 1'b0;
        pause_n                    = 1'b1;
        quad_enable                = 1'b0;
        extended_addressing_enable = 1'b0;
        latency_code_field         = 4'h0;
        training_enable            = 1'b0;
        capture_training_pattern   = 8'hC9;
        oe_seen                    = 1'b0;
        fails                      = 0;
        tests_run                  = 0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        sc_train_wrap();
        sc_cont();
        sc_ext_exit();
        sc_refuse();
        results();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("ERROR %0t run did not finish", $time);
        results();
    end
endmodule
